//--- src/pisp_pkg.sv
// constants, states and opcodes shared by both ends of the two-wire port
// assumes a single 200 MHz clock and an active-low asynchronous reset
//
// Functional notes
// - slave only, any clock rate to 3.4 MHz
// - device never drives or stretches the clock
// - supply cycling keeps register contents
// - both supplies low: both lines released
// - one bit per clock, data stable high
// - data fall is start, rise is stop
// - eight bits msb first, then acknowledge
// - idle until a start is seen
// - repeated start acts like plain start
// - receiver pulls data low to acknowledge
// - master ends with nack and stop
// - every register pointer is acknowledged
// - seven-bit address follows start, then direction
// - main address 0x48 or 0x40 by strap
// - test address 0x49 only when unlocked
// - all other addresses not acknowledged
// - direction bit low writes, high reads
// - master uses main address for traffic
// - master retries after a missing acknowledge
// - general call address never acknowledged
// - stop and power-up restore slow filters
// - stop leaves the register pointer alone
// - first written byte is the pointer
package pisp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QTR_CYC = (SCL_PERIOD_NS * CLK_MHZ) / (4 * 1000);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [1:0] CAP_WAIT = 2'h3;

  // ---------------------------------------------------------------
  // addressing and framing
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MAIN_1 = 7'h48;
  localparam logic [6:0] ADDR_MAIN_0 = 7'h40;
  localparam logic [6:0] ADDR_TEST = 7'h49;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ---------------------------------------------------------------
  // register file and write stream
  // ---------------------------------------------------------------
  localparam int REG_IDX_W = 4;
  localparam logic [7:0] REG_NUM = 8'h10;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int WR_W = 16;
  localparam int FIFO_D = 8;
  localparam logic [5:0] SYNC_RST = 6'h30;

  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_ADDR_ACK, D_PTR, D_PTR_ACK,
    D_WR, D_WR_ACK, D_RD, D_RD_ACK
  } pisp_dst_t;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} pisp_mst_t;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} pisp_op_t;

endpackage : pisp_pkg

//--- src/pisp_bus_if.sv
// the two open-drain bus lines between master end and slave end
// assumes pull-ups: a line is low while any party enables its driver
interface pisp_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl_i;
  logic sda_i;

  // wired-and with pull-up
  assign scl_i = ~(m_scl_oe & ~m_scl_o) & ~(s_scl_oe & ~s_scl_o);
  assign sda_i = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);

  modport dev (input scl_i, input sda_i, output s_scl_o, output s_scl_oe,
               output s_sda_o, output s_sda_oe);
  modport mst (input scl_i, input sda_i, output m_scl_o, output m_scl_oe,
               output m_sda_o, output m_sda_oe);
endinterface : pisp_bus_if

//--- src/pisp_slave_end.sv
// slave end of the two-wire port, its register file and write fifo
// assumes bus lines and supply flags arrive asynchronous to ref_clk

// ---------------------------------------------------------------
// write fifo
// ---------------------------------------------------------------
module pisp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // fill side
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + AW'(1);
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pisp_fifo

// ---------------------------------------------------------------
// slave end
// ---------------------------------------------------------------
module pisp_slave_end (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // bus lines
  pisp_bus_if.dev bus,
  // supplies, strap and test unlock
  input logic io_supply_ok,
  input logic sys_supply_ok,
  input logic addr_sel,
  input logic test_unlock,
  // committed writes: pointer in high byte, data in low byte
  output logic wr_valid,
  input logic wr_ready,
  output logic [pisp_pkg::WR_W-1:0] wr_word,
  // input filter selection
  output logic hs_filter
);
  import pisp_pkg::*;

  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic scl_s, sda_s, io_s, sys_s, asel_s, tunl_s;
  logic scl_p_reg, sda_p_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [1:0] cap_cnt_reg;
  logic [6:0] main_addr_reg;
  pisp_dst_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic oe_reg;
  logic hs_reg;
  logic [7:0] regs_reg [REG_NUM];
  logic [7:0] rd_byte;
  logic addr_hit;
  logic byte_end;
  logic fifo_ready;
  logic wr_take;

  // ---------------------------------------------------------------
  // input synchronisers and line events
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end else begin
      meta_reg <= {bus.scl_i, bus.sda_i, io_supply_ok, sys_supply_ok,
                   addr_sel, test_unlock};
      sync_reg <= meta_reg;
    end
  end
  assign {scl_s, sda_s, io_s, sys_s, asel_s, tunl_s} = sync_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
    end
  end

  // clock comes only from the master; any rate with margin for 2 ff
  assign scl_rise = scl_s & ~scl_p_reg;
  assign scl_fall = ~scl_s & scl_p_reg;
  assign start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
  assign stop_det = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
  assign byte_end = scl_fall & (cnt_reg == BYTE_BITS);

  // ---------------------------------------------------------------
  // strap capture after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_cnt_reg <= '0;
      main_addr_reg <= ADDR_MAIN_0;
    end else if (cap_cnt_reg != CAP_WAIT) begin
      cap_cnt_reg <= cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == CAP_WAIT - 2'h1) begin
        main_addr_reg <= asel_s ? ADDR_MAIN_1 : ADDR_MAIN_0;
      end
    end
  end

  // general call 0x00 never equals either address
  assign addr_hit = (sh_reg[7:1] == main_addr_reg) |
                    (tunl_s & (sh_reg[7:1] == ADDR_TEST));

  // full fifo turns the data acknowledge into nack; no clock stretching
  assign wr_take = io_s & ~start_det & ~stop_det & (state_reg == D_WR) &
                   byte_end & fifo_ready;

  assign rd_byte = (ptr_reg < REG_NUM) ? regs_reg[ptr_reg[REG_IDX_W-1:0]]
                                       : REG_RST;

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= D_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= '0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (!io_s) begin
      state_reg <= D_IDLE;
      oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= D_ADDR;
      cnt_reg <= '0;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= D_IDLE;
      oe_reg <= 1'b0;
    end else begin
      if (scl_rise && (state_reg inside {D_ADDR, D_PTR, D_WR, D_RD})) begin
        sh_reg <= {sh_reg[6:0], sda_s};
        cnt_reg <= cnt_reg + 4'h1;
      end
      if (scl_rise && state_reg == D_RD_ACK) begin
        if (sda_s) begin
          state_reg <= D_IDLE;
        end else begin
          ptr_reg <= ptr_reg + 8'h01;
        end
      end
      if (scl_fall) begin
        unique case (state_reg)
          D_IDLE: begin
          end
          D_ADDR: begin
            if (byte_end) begin
              cnt_reg <= '0;
              if (addr_hit) begin
                state_reg <= D_ADDR_ACK;
                oe_reg <= 1'b1;
                rw_reg <= sh_reg[0];
              end else begin
                state_reg <= D_IDLE;
              end
            end
          end
          D_PTR: begin
            if (byte_end) begin
              cnt_reg <= '0;
              ptr_reg <= sh_reg;
              oe_reg <= 1'b1;
              state_reg <= D_PTR_ACK;
            end
          end
          D_WR: begin
            if (byte_end) begin
              cnt_reg <= '0;
              oe_reg <= wr_take;
              state_reg <= D_WR_ACK;
              if (wr_take) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          D_RD: begin
            if (byte_end) begin
              cnt_reg <= '0;
              oe_reg <= 1'b0;
              state_reg <= D_RD_ACK;
            end else begin
              oe_reg <= ~tx_reg[6];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          D_ADDR_ACK: begin
            if (rw_reg) begin
              state_reg <= D_RD;
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
            end else begin
              state_reg <= D_PTR;
              oe_reg <= 1'b0;
            end
          end
          D_PTR_ACK, D_WR_ACK: begin
            state_reg <= D_WR;
            oe_reg <= 1'b0;
          end
          D_RD_ACK: begin
            state_reg <= D_RD;
            tx_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // register file: reset only by rstn, not by supply loss
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < int'(REG_NUM); i++) begin
        regs_reg[i] <= REG_RST;
      end
    end else if (wr_take && ptr_reg < REG_NUM) begin
      regs_reg[ptr_reg[REG_IDX_W-1:0]] <= sh_reg;
    end
  end

  // ---------------------------------------------------------------
  // input filter selection
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hs_reg <= 1'b0;
    end else if (stop_det || !io_s) begin
      hs_reg <= 1'b0;
    end else if (state_reg == D_ADDR && byte_end &&
                 sh_reg[7:3] == HS_CODE) begin
      hs_reg <= 1'b1;
    end
  end
  assign hs_filter = hs_reg;

  pisp_fifo #(
    .W(WR_W),
    .D(FIFO_D)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(wr_take),
    .in_ready(fifo_ready),
    .in_data({ptr_reg, sh_reg}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // clock line is never driven
  assign bus.s_scl_o = 1'b0;
  assign bus.s_scl_oe = 1'b0;
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_reg & (io_s | sys_s);
endmodule : pisp_slave_end

//--- src/pisp_master_end.sv
// master end of the two-wire port: one bus action per command
// assumes the user retries after a nack and ends reads with nack
module pisp_master_end (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // bus lines
  pisp_bus_if.mst bus,
  // command
  input logic cmd_valid,
  output logic cmd_ready,
  input pisp_pkg::pisp_op_t cmd_op,
  input logic [7:0] cmd_data,
  input logic cmd_nack,
  // response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_acked
);
  import pisp_pkg::*;

  logic sda_meta_reg;
  logic sda_s_reg;
  logic [7:0] qtr_reg;
  logic tick;
  pisp_mst_t state_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg;
  logic [7:0] rx_reg;
  logic ack_reg;
  logic rsp_reg;
  logic scl_rel_reg;
  logic sda_rel_reg;

  // ---------------------------------------------------------------
  // sync and quarter-period divider
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sda_meta_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_meta_reg <= bus.sda_i;
      sda_s_reg <= sda_meta_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      qtr_reg <= '0;
    end else if (state_reg == M_IDLE || qtr_reg == QTR_LAST) begin
      qtr_reg <= '0;
    end else begin
      qtr_reg <= qtr_reg + 8'h01;
    end
  end
  assign tick = (state_reg != M_IDLE) && (qtr_reg == QTR_LAST);

  // ---------------------------------------------------------------
  // bus sequencer: bit data moves only in phase 0, clock low; start and stop also move data in phase 2, clock high
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= M_IDLE;
      ph_reg <= '0;
      bit_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      ack_reg <= 1'b0;
      rsp_reg <= 1'b0;
      scl_rel_reg <= 1'b1;
      sda_rel_reg <= 1'b1;
    end else begin
      rsp_reg <= 1'b0;
      if (state_reg == M_IDLE) begin
        if (cmd_valid) begin
          ph_reg <= '0;
          bit_reg <= '0;
          unique case (cmd_op)
            OP_START: state_reg <= M_START;
            OP_STOP: state_reg <= M_STOP;
            OP_WRITE: begin
              state_reg <= M_BIT;
              tx_reg <= {cmd_data, 1'b1};
            end
            OP_READ: begin
              state_reg <= M_BIT;
              tx_reg <= {8'hFF, cmd_nack};
            end
          endcase
        end
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        unique case (state_reg)
          M_START: begin
            unique case (ph_reg)
              2'h0: sda_rel_reg <= 1'b1;
              2'h1: scl_rel_reg <= 1'b1;
              2'h2: sda_rel_reg <= 1'b0;
              2'h3: begin
                scl_rel_reg <= 1'b0;
                state_reg <= M_IDLE;
              end
            endcase
          end
          M_STOP: begin
            unique case (ph_reg)
              2'h0: sda_rel_reg <= 1'b0;
              2'h1: scl_rel_reg <= 1'b1;
              2'h2: sda_rel_reg <= 1'b1;
              2'h3: state_reg <= M_IDLE;
            endcase
          end
          M_BIT: begin
            unique case (ph_reg)
              2'h0: sda_rel_reg <= tx_reg[8];
              2'h1: scl_rel_reg <= 1'b1;
              2'h2: begin
                if (bit_reg == BYTE_BITS) begin
                  ack_reg <= ~sda_s_reg;
                end else begin
                  rx_reg <= {rx_reg[6:0], sda_s_reg};
                end
              end
              2'h3: begin
                scl_rel_reg <= 1'b0;
                tx_reg <= {tx_reg[7:0], 1'b1};
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == BYTE_BITS) begin
                  state_reg <= M_IDLE;
                  rsp_reg <= 1'b1;
                end
              end
            endcase
          end
          M_IDLE: begin
          end
        endcase
      end
    end
  end

  assign cmd_ready = (state_reg == M_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_data = rx_reg;
  assign rsp_acked = ack_reg;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = ~scl_rel_reg;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = ~sda_rel_reg;
endmodule : pisp_master_end

//--- dv/pisp_checker.sv
// concurrent checks on the two-wire link between master end and slave end
// assumes the signals of one pisp_bus_if, all sampled on ref_clk
module pisp_checker
  import pisp_pkg::*;
(
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // slave drivers
  input logic s_scl_oe,
  input logic s_sda_o,
  input logic s_sda_oe,
  // resolved lines
  input logic scl_i,
  input logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // helper logic: line history, rise count and first byte of a frame
  // ---------------------------------------------------------------
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic wr_acked;
  logic [7:0] rises;
  logic [7:0] first_byte;
  logic start_seen;
  logic stop_seen;
  logic rise_seen;

  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;
  assign rise_seen = scl_i & ~scl_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // saturating, so a long read never wraps into an address slot
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rises <= 8'h00;
    end else if (start_seen) begin
      rises <= 8'h00;
    end else if (rise_seen && rises != 8'hFF) begin
      rises <= rises + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_byte <= 8'h00;
    end else if (rise_seen && rises < 8'h08) begin
      first_byte <= {first_byte[6:0], sda_i};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_acked <= 1'b0;
    end else if (start_seen) begin
      wr_acked <= 1'b0;
    end else if (rise_seen && rises == 8'h08) begin
      wr_acked <= ~sda_i & ~first_byte[0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_frame <= 1'b0;
    end else if (start_seen) begin
      in_frame <= 1'b1;
    end else if (stop_seen) begin
      in_frame <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_pull;
    $rose(s_sda_oe);
  endsequence

  sequence s_low_rise;
    $rose(scl_i) && !sda_i;
  endsequence

  property p_pull_seen_high;
    s_pull |-> ##[1:400] s_low_rise;
  endproperty

  chk_scl_never_driven: assert property (!s_scl_oe)
    else $error("slave drives the clock line");
  chk_sda_open_drain: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave drives data high");
  chk_sda_stable_high: assert property (
    scl_i && $past(scl_i) |-> $stable(s_sda_oe))
    else $error("slave data changed while clock high");
  chk_ack_before_rise: assert property (p_pull_seen_high)
    else $error("slave pull not held over next clock rise");
  chk_ack_slot_count: assert property (s_pull |-> rises >= 8'h08)
    else $error("slave pulled data before the ninth clock");
  chk_addr_legal: assert property (
    s_pull and rises == 8'h08 |-> first_byte[7:1] == ADDR_MAIN_1
      || first_byte[7:1] == ADDR_MAIN_0 || first_byte[7:1] == ADDR_TEST)
    else $error("slave acked a foreign address");
  chk_ptr_always_ack: assert property (
    $fell(scl_i) && rises == 8'h11 && wr_acked |-> ##[1:8] s_sda_oe)
    else $error("register pointer not acked");
  chk_idle_released: assert property (!in_frame |-> !s_sda_oe)
    else $error("slave pulls data outside a frame");
endmodule : pisp_checker

//--- dv/pmic_i2c_slave_port_tb.sv
// self-checking bench: master end and slave end joined by pisp_bus_if
// assumes the design files of src/ are compiled first
module pmic_i2c_slave_port_tb import pisp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // clock, stimulus and instances
  // ---------------------------------------------------------------
  localparam int LIMIT = 80000;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic io_supply_ok = 1'b1;
  logic sys_supply_ok = 1'b1;
  logic addr_sel = 1'b1;
  logic test_unlock = 1'b0;
  logic wr_ready = 1'b0;
  logic cmd_valid = 1'b0;
  pisp_op_t cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic wr_valid;
  logic [WR_W-1:0] wr_word;
  logic hs_filter;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_acked;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] mon_byte = 8'h00;
  int mon_cnt = 8;

  always #2.5 ref_clk = ~ref_clk;

  pisp_bus_if bus ();
  pisp_slave_end i_pisp_slave_end (.ref_clk(ref_clk), .rstn(rstn),
    .bus(bus.dev), .io_supply_ok(io_supply_ok),
    .sys_supply_ok(sys_supply_ok), .addr_sel(addr_sel),
    .test_unlock(test_unlock), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .hs_filter(hs_filter));
  pisp_master_end i_pisp_master_end (.ref_clk(ref_clk), .rstn(rstn),
    .bus(bus.mst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked));
  pisp_checker i_pisp_checker (.ref_clk(ref_clk), .rstn(rstn),
    .s_scl_oe(bus.s_scl_oe), .s_sda_o(bus.s_sda_o),
    .s_sda_oe(bus.s_sda_oe), .scl_i(bus.scl_i), .sda_i(bus.sda_i));

  // wire monitor: first eight bits after each start, as seen on the line
  always @(posedge ref_clk) begin
    scl_q <= bus.scl_i;
    sda_q <= bus.sda_i;
    if (bus.scl_i && scl_q && sda_q && !bus.sda_i) begin
      mon_cnt <= 0;
    end else if (bus.scl_i && !scl_q && mon_cnt < 8) begin
      mon_byte <= {mon_byte[6:0], bus.sda_i};
      mon_cnt <= mon_cnt + 1;
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic do_reset(input logic sel);
    @(posedge ref_clk);
    rstn <= 1'b0;
    addr_sel <= sel;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : do_reset

  // one command; byte commands return at the rsp_valid pulse
  task automatic cmd(input pisp_op_t op, input logic [7:0] d,
                     input logic nk);
    int i;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_nack <= nk;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 6000);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (((op == OP_WRITE || op == OP_READ) ? rsp_valid : cmd_ready)
               !== 1'b1 && i < 6000);
    // a hung master counts as a mismatch and ends the run
    if (i >= 6000) begin
      n_mismatch++;
      test_done();
    end
  endtask : cmd

  task automatic wr(input logic [7:0] d, input logic ea);
    cmd(OP_WRITE, d, 1'b0);
    check({15'h0000, rsp_acked}, {15'h0000, ea});
  endtask : wr

  task automatic rd(input logic nk, input logic [7:0] e);
    cmd(OP_READ, 8'h00, nk);
    check({8'h00, rsp_data}, {8'h00, e});
  endtask : rd

  task automatic probe(input logic [6:0] a, input logic ea);
    cmd(OP_START, 8'h00, 1'b0);
    wr({a, 1'b0}, ea);
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask : probe

  task automatic idle_check;
    repeat (20) @(negedge ref_clk);
    check({14'h0000, bus.scl_i, bus.sda_i}, 16'h0003);
  endtask : idle_check

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_write_fill;
    int n;
    int g;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h90, 1'b1);
    check({8'h00, mon_byte}, 16'h0090);
    wr(8'h0C, 1'b1);
    for (n = 0; n < FIFO_D; n++) begin
      wr(8'hA5 + 8'(n), 1'b1);
    end
    wr(8'hAD, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    idle_check();
    // drain with the writer gone, checking fifo order then empty
    @(posedge ref_clk);
    wr_ready <= 1'b1;
    n = 0;
    g = 0;
    while (n < FIFO_D && g < 200) begin
      @(negedge ref_clk);
      g++;
      if (wr_valid === 1'b1) begin
        check(wr_word, {8'h0C + 8'(n), 8'hA5 + 8'(n)});
        n++;
      end
    end
    check(16'(n), 16'(FIFO_D));
    @(posedge ref_clk);
    wr_ready <= 1'b0;
    @(negedge ref_clk);
    check({15'h0000, wr_valid}, 16'h0000);
  endtask : t_write_fill

  task automatic t_supply;
    @(posedge ref_clk);
    io_supply_ok <= 1'b0;
    sys_supply_ok <= 1'b0;
    repeat (10) @(posedge ref_clk);
    probe(7'h48, 1'b0);
    @(posedge ref_clk);
    io_supply_ok <= 1'b1;
    sys_supply_ok <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask : t_supply

  task automatic t_read;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h90, 1'b1);
    wr(8'h0C, 1'b1);
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h91, 1'b1);
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'hA6);
    cmd(OP_STOP, 8'h00, 1'b0);
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h91, 1'b1);
    rd(1'b1, 8'hA6);
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask : t_read

  task automatic t_filter;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h08, 1'b0);
    check({15'h0000, hs_filter}, 16'h0001);
    cmd(OP_START, 8'h00, 1'b0);
    check({15'h0000, hs_filter}, 16'h0001);
    wr(8'h90, 1'b1);
    wr(8'hF7, 1'b1);
    cmd(OP_STOP, 8'h00, 1'b0);
    idle_check();
    check({15'h0000, hs_filter}, 16'h0000);
  endtask : t_filter

  task automatic t_addr;
    @(posedge ref_clk);
    test_unlock <= 1'b0;
    probe(7'h49, 1'b0);
    probe(7'h00, 1'b0);
    @(posedge ref_clk);
    test_unlock <= 1'b1;
    probe(7'h49, 1'b1);
    // strap is taken only after reset, so a second reset changes it
    do_reset(1'b0);
    probe(7'h40, 1'b1);
    probe(7'h48, 1'b0);
  endtask : t_addr

  initial begin
    do_reset(1'b1);
    idle_check();
    check({14'h0000, hs_filter, wr_valid}, 16'h0000);
    t_write_fill();
    t_supply();
    t_read();
    t_filter();
    t_addr();
    test_done();
  end
endmodule : pmic_i2c_slave_port_tb
